/* File: hdl/dacsr_top.sv */
// accumulator datapath: 40-bit adder, saturation, round and write saturation, apb registers
//
// Contract
// (RULE1) 40-bit signed adder takes and writes back accumulator A or B.
// (RULE2) add and load operands may be scaled by the barrel shifter first.
// (RULE3) add uses true operand with carry; subtract complements with active-low borrow.
// (RULE4) each adder op sets target guard flag when bits 39..32 differ.
// (RULE5) guard flag plus its accumulator trap enable raises a warning trap.
// (RULE6) saturation flags are sticky; only a software write clears them.
// (RULE7) saturation flag means bit 31 or bit 39 overflow, per width mode.
// (RULE8) saturation disabled, catastrophic enable and flag set raise a trap.
// (RULE9) status shows OR of guard flags and OR of saturation flags.
// (RULE10) saturation uses result, overflow, enables at bits 7:6, width at 4.
// (RULE11) 40-bit mode clips to 7FFFFFFFFF or 8000000000 and sets flag.
// (RULE12) 32-bit mode clips to 007FFFFFFF or 0080000000 and sets flag.
// (RULE13) in 32-bit mode guard flags and their OR never set; the code suppresses them only while saturation of the target is enabled.
// (RULE14) without saturation the accumulator wraps; bit 39 overflow sets flag.
// (RULE15) mac class except multiply, negated, squared ops may write back.
// (RULE16) write-back goes into working register or its address, then plus 2.
// (RULE17) round logic is combinational 1.15; truncation drops the low word.
// (RULE18) conventional rounding adds bit 15 into the high word.
// (RULE19) convergent rounding on exact 8000 low word increments only if bit 16.
// (RULE20) truncated store never rounded; rounded store and mac write-back always rounded.
// (RULE21) write saturation clips to 7FFF or 8000, sign from bit 39.
// (RULE22) write saturation off passes the 1.15 word unmodified.
`timescale 1ns/1ps
`default_nettype none
module dacsr_top
	import dacsr_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output dacsr_xwr_s xwr,
	output logic arith_trap
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// state
	logic [7:0] cfg_reg;
	logic [2:0] trap_en_reg;
	logic [39:0] acc_a_reg, acc_b_reg;
	logic guard_a_reg, guard_b_reg, sat_a_reg, sat_b_reg, trap_seen_reg;
	logic [31:0] operand_reg;
	logic [15:0] wb_reg, store_word_reg;

	// apb decode; no wait state, read data comes from a flop loaded in the setup cycle
	wire logic [7:0] addr8 = paddr[7:0];
	wire logic hi_zero = (ADDR_W > 8) ? ~|(paddr >> 8) : 1'b1;
	wire logic setup = psel & ~penable;
	wire logic mapped = hi_zero & (addr8[1:0] == 2'b00) & (addr8 <= OFF_STORE_WORD);
	wire logic fire = psel & penable & pready & ~pslverr;
	wire logic wr_fire = fire & pwrite;
	wire logic wr_cfg = wr_fire & (addr8 == OFF_CORE_CFG);
	wire logic wr_trp = wr_fire & (addr8 == OFF_TRAP_CTL);
	wire logic wr_st = wr_fire & (addr8 == OFF_STATUS);
	wire logic wr_opnd = wr_fire & (addr8 == OFF_OPERAND);
	wire logic wr_wb = wr_fire & (addr8 == OFF_WB_REG);
	wire logic exec = wr_fire & (addr8 == OFF_COMMAND);

	// command fields
	wire dacsr_op_e op = dacsr_op_e'(pwdata[CMD_OP_MSB:0]);
	wire logic tgt_b = pwdata[CMD_TGT_B];
	wire logic signed [4:0] sh_amt = pwdata[CMD_SH_MSB:CMD_SH_LSB];
	wire logic cin = pwdata[CMD_CARRY];
	wire logic is_add_path = (op == OP_ADD) | (op == OP_SUB) | (op == OP_LOAD)
		| (op == OP_MAC) | (op == OP_MSC) | (op == OP_MPY) | (op == OP_NEGATED_MULTIPLY)
		| (op == OP_ED) | (op == OP_SQUARED_DIFFERENCE_ACCUMULATE);
	wire logic uses_acc = (op == OP_ADD) | (op == OP_SUB) | (op == OP_MAC)
		| (op == OP_MSC) | (op == OP_SQUARED_DIFFERENCE_ACCUMULATE);
	wire logic negate = (op == OP_SUB) | (op == OP_MSC) | (op == OP_NEGATED_MULTIPLY);
	wire logic shift_ok = (op == OP_ADD) | (op == OP_LOAD);
	wire logic is_store = (op == OP_STORE_T) | (op == OP_STORE_R);
	wire logic adder_go = exec & is_add_path;

	// (RULE1) target accumulator selection
	wire logic [39:0] acc_t = tgt_b ? acc_b_reg : acc_a_reg;
	wire logic [39:0] acc_n = tgt_b ? acc_a_reg : acc_b_reg;

	// (RULE2) barrel scaling; positive shifts right, negative left
	wire logic signed [39:0] opnd40 = {{8{operand_reg[31]}}, operand_reg};
	wire logic [4:0] sh_mag = sh_amt[4] ? 5'(-sh_amt) : 5'(sh_amt);
	wire logic [39:0] opnd_sh = sh_amt[4] ? (opnd40 << sh_mag) : 40'(opnd40 >>> sh_mag);
	wire logic [39:0] opnd = shift_ok ? opnd_sh : opnd40;

	// (RULE3) zero or accumulator on one side, true or complement on the other
	wire logic [39:0] side_a = uses_acc ? acc_t : 40'h00_0000_0000;
	wire logic [39:0] side_b = negate ? ~opnd : opnd;
	wire logic [40:0] sum41 = {side_a[39], side_a} + {side_b[39], side_b} + {40'h00_0000_0000, cin};

	// overflow detection on the sign-extended sum
	wire logic ovf39 = sum41[40] ^ sum41[39];
	wire logic guard_raw = ~((&sum41[39:32]) | ~(|sum41[39:32]));
	wire logic ovf31 = ~((&sum41[39:31]) | ~(|sum41[39:31])) | ovf39;
	wire logic res_neg = sum41[40];

	// (RULE10) saturation decision from result, enables and width select
	wire logic sat_en = tgt_b ? cfg_reg[CFG_ACC_B_SATURATION_ENABLE] : cfg_reg[CFG_ACC_A_SATURATION_ENABLE];
	wire logic w40 = cfg_reg[CFG_WIDTH40];
	// (RULE7) overflow point depends on width mode; bit 39 when disabled
	wire logic sat_hit = (sat_en & ~w40) ? ovf31 : ovf39;
	wire logic clip = sat_en & sat_hit;
	// (RULE13) guard bits unused in 32-bit saturation
	wire logic guard_new = guard_raw & ~(sat_en & ~w40);
	// (RULE11) (RULE12) clip values by width and sign
	wire logic [39:0] clip_val = w40 ? (res_neg ? SAT40_MIN : SAT40_MAX)
		: (res_neg ? SAT32_MIN : SAT32_MAX);
	// (RULE14) no saturation: wrapped sum is kept
	wire logic [39:0] result = clip ? clip_val : sum41[39:0];

	// trap sources for the target accumulator
	wire logic ovte_t = tgt_b ? trap_en_reg[TRP_OVB] : trap_en_reg[TRP_OVA];
	wire logic sat_old_t = tgt_b ? sat_b_reg : sat_a_reg;
	// (RULE5) guard overflow trap
	wire logic trap_guard = guard_new & ovte_t;
	// (RULE8) catastrophic trap while saturation is off
	wire logic trap_cat = ~sat_en & trap_en_reg[TRP_COV] & (sat_old_t | sat_hit);
	wire logic trap_now = adder_go & (trap_guard | trap_cat);

	// (RULE15) write-back only for accumulate and subtract-accumulate
	wire logic wb_fire = exec & ((op == OP_MAC) | (op == OP_MSC)) & pwdata[CMD_WB_EN];
	wire logic wb_ind = pwdata[CMD_WB_IND];
	wire logic store_fire = exec & is_store;

	// (RULE17) combinational round; stores read target, write-back the other acc
	wire logic [39:0] src = is_store ? acc_t : acc_n;
	// (RULE20) truncated store never rounds, write-back always rounds
	wire logic round_on = (op == OP_STORE_R) | wb_fire;
	// (RULE18) (RULE19) conventional adds bit 15; convergent breaks ties on bit 16
	wire logic tie = (src[15:0] == ROUND_TIE);
	wire logic inc = round_on & src[15] & (~cfg_reg[CFG_RND] | ~tie | src[16]);
	wire logic [23:0] r24 = src[39:16] + {23'h00_0000, inc};

	// (RULE21) write saturation, sign taken from the source msb
	wire logic pos_over = ~src[39] & (r24 > DW_POS_LIMIT);
	wire logic neg_under = src[39] & (r24 < DW_NEG_LIMIT);
	// (RULE22) write saturation off leaves the word untouched
	wire logic [15:0] dw_word = ~cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE] ? r24[15:0]
		: pos_over ? DW_MAX : neg_under ? DW_MIN : r24[15:0];

	// (RULE9) status word view
	wire logic either_guard_overflow = guard_a_reg | guard_b_reg;
	wire logic either_saturated = sat_a_reg | sat_b_reg;
	wire logic [31:0] status_word = {25'h000_0000, trap_seen_reg, either_saturated,
		either_guard_overflow, sat_b_reg, sat_a_reg, guard_b_reg, guard_a_reg};

	// read multiplexer, sampled in the setup cycle
	logic [31:0] rd_mux;
	always_comb begin
		case (addr8)
			OFF_CORE_CFG: rd_mux = {24'h00_0000, cfg_reg};
			OFF_TRAP_CTL: rd_mux = {29'h0000_0000, trap_en_reg};
			OFF_STATUS: rd_mux = status_word;
			OFF_ACC_A_LO: rd_mux = acc_a_reg[31:0];
			OFF_ACC_A_HI: rd_mux = {{24{acc_a_reg[39]}}, acc_a_reg[39:32]};
			OFF_ACC_B_LO: rd_mux = acc_b_reg[31:0];
			OFF_ACC_B_HI: rd_mux = {{24{acc_b_reg[39]}}, acc_b_reg[39:32]};
			OFF_OPERAND: rd_mux = operand_reg;
			OFF_WB_REG: rd_mux = {16'h0000, wb_reg};
			OFF_STORE_WORD: rd_mux = {16'h0000, store_word_reg};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// bus answer: ready in the first access cycle, error for holes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~mapped;
			if (setup) begin
				prdata <= mapped ? rd_mux : 32'h0000_0000;
			end
		end
	end

	// configuration and trap enables
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_reg <= CFG_RESET;
			trap_en_reg <= TRP_RESET;
			operand_reg <= 32'h0000_0000;
		end else begin
			if (wr_cfg) cfg_reg <= pwdata[7:0];
			if (wr_trp) trap_en_reg <= pwdata[2:0];
			if (wr_opnd) operand_reg <= pwdata;
		end
	end

	// (RULE1) accumulator write-back of the adder result
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_a_reg <= 40'h00_0000_0000;
			acc_b_reg <= 40'h00_0000_0000;
		end else if (adder_go) begin
			if (tgt_b) acc_b_reg <= result;
			else acc_a_reg <= result;
		end
	end

	// (RULE4) guard flags follow every adder op on the target
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			guard_a_reg <= 1'b0;
			guard_b_reg <= 1'b0;
		end else if (adder_go) begin
			if (tgt_b) guard_b_reg <= guard_new;
			else guard_a_reg <= guard_new;
		end
	end

	// (RULE6) sticky flags: write one to clear, a same-cycle set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sat_a_reg <= 1'b0;
			sat_b_reg <= 1'b0;
			trap_seen_reg <= 1'b0;
		end else begin
			sat_a_reg <= (adder_go & ~tgt_b & sat_hit) | (sat_a_reg & ~(wr_st & pwdata[ST_SA]));
			sat_b_reg <= (adder_go & tgt_b & sat_hit) | (sat_b_reg & ~(wr_st & pwdata[ST_SB]));
			trap_seen_reg <= trap_now | (trap_seen_reg & ~(wr_st & pwdata[ST_TRAP]));
		end
	end

	// trap pulse towards the exception logic
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) arith_trap <= 1'b0;
		else arith_trap <= trap_now;
	end

	// (RULE16) write-back destination register and post-increment
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wb_reg <= 16'h0000;
		end else if (wb_fire) begin
			wb_reg <= wb_ind ? 16'(wb_reg + WB_STEP) : dw_word;
		end else if (wr_wb) begin
			wb_reg <= pwdata[15:0];
		end
	end

	// x bus write, one cycle; stores go to the operand's low half as address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xwr <= '0;
			store_word_reg <= 16'h0000;
		end else begin
			xwr.en <= store_fire | (wb_fire & wb_ind);
			if (store_fire | wb_fire) begin
				xwr.addr <= store_fire ? operand_reg[15:0] : wb_reg;
				xwr.data <= dw_word;
				store_word_reg <= dw_word;
			end
		end
	end

	// checks
	sequence s_cmd_a;
		adder_go && !tgt_b;
	endsequence

	sequence s_cmd_b;
		adder_go && tgt_b;
	endsequence

	sequence s_wb_indirect;
		wb_fire && wb_ind;
	endsequence

	// (RULE4) guard flag tracks the raw guard bits
	a_guard_flag_update: assert property (s_cmd_a and !(sat_en && !w40) |=> // (RULE4)
		guard_a_reg == $past(guard_raw))
		else $error("guard flag A not updated from result");

	// (RULE4) guard flag B follows ops on B
	a_guard_b_update: assert property (s_cmd_b and !(sat_en && !w40) // (RULE4)
		|=> guard_b_reg == $past(guard_raw))
		else $error("guard flag B not updated from result");

	// (RULE13) never set in 32-bit saturation mode
	a_guard_off_32: assert property (s_cmd_a and (sat_en && !w40) |=> !guard_a_reg) // (RULE13)
		else $error("guard flag set in 32-bit saturation");

	// (RULE6) sticky until software clears
	a_sat_sticky: assert property (sat_a_reg && !(wr_st && pwdata[ST_SA]) // (RULE6)
		|=> sat_a_reg)
		else $error("saturation flag A dropped without clear");

	// (RULE6) flag B sticky as well
	a_sat_b_sticky: assert property (sat_b_reg && !(wr_st && pwdata[ST_SB]) // (RULE6)
		|=> sat_b_reg)
		else $error("saturation flag B dropped without clear");

	// (RULE11) positive 40-bit clip
	a_sat40_clip: assert property (s_cmd_a and (sat_en && w40 && ovf39 && !res_neg) // (RULE11)
		|=> acc_a_reg == SAT40_MAX && sat_a_reg)
		else $error("40-bit positive clip wrong");

	// (RULE11) negative 40-bit clip on B
	a_sat40_neg: assert property (s_cmd_b and (sat_en && w40 && ovf39 && res_neg) // (RULE11)
		|=> acc_b_reg == SAT40_MIN && sat_b_reg)
		else $error("40-bit negative clip wrong");

	// (RULE12) negative 32-bit clip
	a_sat32_clip: assert property (s_cmd_a and (sat_en && !w40 && ovf31 && res_neg) // (RULE12)
		|=> acc_a_reg == SAT32_MIN && sat_a_reg)
		else $error("32-bit negative clip wrong");

	// (RULE14) wrap and flag without saturation
	a_wrap_cat: assert property (s_cmd_a and (!sat_en && ovf39) // (RULE14)
		|=> acc_a_reg == $past(sum41[39:0]) && sat_a_reg)
		else $error("catastrophic overflow not wrapped or flagged");

	// (RULE5) guard trap pulse
	a_guard_trap: assert property (adder_go && guard_new && ovte_t // (RULE5)
		|=> arith_trap ##1 !arith_trap)
		else $error("guard overflow trap missing");

	// (RULE8) catastrophic trap with saturation off
	a_cat_trap: assert property (adder_go && !sat_en && trap_en_reg[TRP_COV] && sat_hit // (RULE8)
		|=> arith_trap)
		else $error("catastrophic overflow trap missing");

	// (RULE9) status read shows the ORs
	a_status_or: assert property (setup && mapped && addr8 == OFF_STATUS |=> // (RULE9)
		prdata[ST_SAB] == (sat_a_reg | sat_b_reg) && prdata[ST_OAB] == either_guard_overflow)
		else $error("combined status bits wrong");

	// (RULE17) truncated store drops the low word
	a_trunc_store: assert property (store_fire && op == OP_STORE_T // (RULE17)
		&& !cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE] |=> xwr.en && xwr.data == $past(acc_t[31:16]))
		else $error("truncated store data wrong");

	// (RULE18) conventional rounding
	a_round_conv: assert property (store_fire && op == OP_STORE_R // (RULE18)
		&& !cfg_reg[CFG_RND] && !cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE]
		|=> xwr.data == 16'($past(acc_t[31:16]) + $past(acc_t[15])))
		else $error("conventional rounding wrong");

	// (RULE19) convergent tie follows bit 16
	a_round_tie: assert property (store_fire && op == OP_STORE_R && cfg_reg[CFG_RND] // (RULE19)
		&& !cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE] && acc_t[15:0] == ROUND_TIE
		|=> xwr.data == 16'($past(acc_t[31:16]) + $past(acc_t[16])))
		else $error("convergent rounding tie wrong");

	// (RULE21) positive write saturation
	a_dw_clip: assert property (store_fire && cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE] && pos_over |=> // (RULE21)
		xwr.data == DW_MAX)
		else $error("data write saturation wrong");

	// (RULE21) negative write saturation
	a_dw_clip_neg: assert property (store_fire && cfg_reg[CFG_DATA_WRITE_SATURATION_ENABLE] && neg_under // (RULE21)
		|=> xwr.data == DW_MIN)
		else $error("negative data write saturation wrong");

	// (RULE15) excluded mac ops never write back
	a_no_wb_excl: assert property (exec && pwdata[CMD_WB_EN] && (op == OP_MPY // (RULE15)
		|| op == OP_NEGATED_MULTIPLY || op == OP_ED || op == OP_SQUARED_DIFFERENCE_ACCUMULATE) |=> !xwr.en && $stable(wb_reg))
		else $error("excluded operation wrote back");

	// (RULE16) indirect write-back then increment by two
	a_wb_incr: assert property (s_wb_indirect |=> xwr.en && xwr.addr == $past(wb_reg) // (RULE16)
		&& wb_reg == 16'($past(wb_reg) + WB_STEP))
		else $error("indirect write-back address or increment wrong");

	// (RULE16) direct write-back fills the register, no bus write
	a_wb_direct: assert property (wb_fire && !wb_ind // (RULE16)
		|=> !xwr.en && wb_reg == xwr.data)
		else $error("direct write-back wrong");
endmodule // dacsr_top
`default_nettype wire

/* File: common/dacsr_pkg.sv */
// package: register map, field layout, constants and types of the accumulator datapath
`default_nettype none
package dacsr_pkg;
	// register byte offsets
	localparam logic [7:0] OFF_CORE_CFG = 8'h00;
	localparam logic [7:0] OFF_TRAP_CTL = 8'h04;
	localparam logic [7:0] OFF_STATUS = 8'h08;
	localparam logic [7:0] OFF_ACC_A_LO = 8'h0C;
	localparam logic [7:0] OFF_ACC_A_HI = 8'h10;
	localparam logic [7:0] OFF_ACC_B_LO = 8'h14;
	localparam logic [7:0] OFF_ACC_B_HI = 8'h18;
	localparam logic [7:0] OFF_OPERAND = 8'h1C;
	localparam logic [7:0] OFF_COMMAND = 8'h20;
	localparam logic [7:0] OFF_WB_REG = 8'h24;
	localparam logic [7:0] OFF_STORE_WORD = 8'h28;
	// core configuration fields
	localparam int CFG_ACC_A_SATURATION_ENABLE = 7;
	localparam int CFG_ACC_B_SATURATION_ENABLE = 6;
	localparam int CFG_DATA_WRITE_SATURATION_ENABLE = 5;
	localparam int CFG_WIDTH40 = 4;
	localparam int CFG_RND = 1;
	localparam logic [7:0] CFG_RESET = 8'h00;
	// trap control fields
	localparam int TRP_OVA = 0;
	localparam int TRP_OVB = 1;
	localparam int TRP_COV = 2;
	localparam logic [2:0] TRP_RESET = 3'h0;
	// status fields
	localparam int ST_OA = 0;
	localparam int ST_OB = 1;
	localparam int ST_SA = 2;
	localparam int ST_SB = 3;
	localparam int ST_OAB = 4;
	localparam int ST_SAB = 5;
	localparam int ST_TRAP = 6;
	// command fields
	localparam int CMD_OP_MSB = 3;
	localparam int CMD_TGT_B = 4;
	localparam int CMD_SH_LSB = 5;
	localparam int CMD_SH_MSB = 9;
	localparam int CMD_CARRY = 10;
	localparam int CMD_WB_EN = 11;
	localparam int CMD_WB_IND = 12;
	// saturation values
	localparam logic [39:0] SAT40_MAX = 40'h7F_FFFF_FFFF;
	localparam logic [39:0] SAT40_MIN = 40'h80_0000_0000;
	localparam logic [39:0] SAT32_MAX = 40'h00_7FFF_FFFF;
	localparam logic [39:0] SAT32_MIN = 40'h00_8000_0000;
	localparam logic [23:0] DW_POS_LIMIT = 24'h00_7FFF;
	localparam logic [23:0] DW_NEG_LIMIT = 24'hFF_8000;
	localparam logic [15:0] DW_MAX = 16'h7FFF;
	localparam logic [15:0] DW_MIN = 16'h8000;
	localparam logic [15:0] ROUND_TIE = 16'h8000;
	localparam logic [15:0] WB_STEP = 16'h0002;
	// operations, encoded in order in the command op field
	typedef enum logic [3:0] {
		OP_NOP, OP_ADD, OP_SUB, OP_LOAD, OP_STORE_T, OP_STORE_R,
		OP_MAC, OP_MSC, OP_MPY, OP_NEGATED_MULTIPLY, OP_ED, OP_SQUARED_DIFFERENCE_ACCUMULATE
	} dacsr_op_e;
	// one data-space write on the x bus
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [15:0] data;
	} dacsr_xwr_s;
endpackage
`default_nettype wire

/* File: sim/dacsr_xmem.sv */
// x data bus partner: takes each data-space write and keeps the last one
`timescale 1ns/1ps
`default_nettype none
module dacsr_xmem
	import dacsr_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire dacsr_xwr_s xwr,
	output logic [15:0] last_addr,
	output logic [15:0] last_data,
	output logic [7:0] wr_count
);
	// memory side never stalls a write, so the count exposes any stretched strobe
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_addr <= 16'h0000;
			last_data <= 16'h0000;
			wr_count <= 8'h00;
		end else if (xwr.en === 1'b1) begin
			last_addr <= xwr.addr;
			last_data <= xwr.data;
			wr_count <= wr_count + 8'h01;
		end
	end
endmodule // dacsr_xmem
`default_nettype wire

/* File: sim/tb_dsp_accumulator_saturation_round.sv */
// self-checking bench for the accumulator datapath
`timescale 1ns/1ps
`default_nettype none
module tb_dsp_accumulator_saturation_round;
	import dacsr_pkg::*;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready, pslverr, arith_trap, last_err;
	dacsr_xwr_s xwr;
	logic [15:0] xm_addr, xm_data;
	logic [7:0] xm_count, t0;
	logic [7:0] traps = 8'h00;
	logic [31:0] rd;
	int mismatches = 0;
	int tests_run = 0;
	// clock and instances
	always #12.5 pclk = ~pclk;
	dacsr_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .xwr(xwr), .arith_trap(arith_trap));
	dacsr_xmem i_xmem (.pclk(pclk), .presetn(presetn), .xwr(xwr), .last_addr(xm_addr),
		.last_data(xm_data), .wr_count(xm_count));
	// count trap pulses; a stuck trap line shows up as an extra count
	always @(posedge pclk) if (arith_trap === 1'b1) traps <= traps + 8'h01;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// one apb transfer; request held until pready is seen at a rising edge
	// no local limit: a slave that never answers is caught by the watchdog
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000);
		chk(rd, e);
	endtask
	function automatic logic [31:0] cw(input logic [3:0] op, input logic b, input logic [4:0] sh,
			input logic c, input logic wb, input logic ind);
		return {19'h0_0000, ind, wb, c, sh, b, op};
	endfunction
	// run one command on a fresh operand
	task automatic run(input logic [31:0] v, input logic [31:0] c);
		wr(OFF_OPERAND, v);
		wr(OFF_COMMAND, c);
	endtask
	task automatic acc(input logic b, input logic [39:0] e);
		rdc(b ? OFF_ACC_B_LO : OFF_ACC_A_LO, e[31:0]);
		rdc(b ? OFF_ACC_B_HI : OFF_ACC_A_HI, {{24{e[39]}}, e[39:32]});
	endtask
	// reset values and an unmapped offset
	task automatic t_regs;
		rdc(OFF_CORE_CFG, 32'h0000_0000);
		rdc(OFF_STATUS, 32'h0000_0000);
		apb(1'b0, 8'h2C, 32'h0000_0000);
		chk({31'h0, last_err}, 32'h0000_0001);
		$display("test regs done");
	endtask
	// guard overflow through a left-scaled load, with its trap
	task automatic t_guard;
		wr(OFF_CORE_CFG, 32'h0000_0010);
		wr(OFF_TRAP_CTL, 32'h0000_0001);
		t0 = traps;
		run(32'h7FFF_FFFF, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, 40'h7F_FFFF_FF00);
		chk({24'h0, traps - t0}, 32'h0000_0001);
		rdc(OFF_STATUS, 32'h0000_0051);
		wr(OFF_STATUS, 32'h0000_004C);
		rdc(OFF_STATUS, 32'h0000_0011);
		run(32'h0000_0000, cw(OP_LOAD, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0));
		rdc(OFF_STATUS, 32'h0000_0000);
		chk({24'h0, traps - t0}, 32'h0000_0001);
		wr(OFF_TRAP_CTL, 32'h0000_0000);
		$display("test guard done");
	endtask
	// 40-bit clipping on A only, B wraps, flags stay set
	task automatic t_sat40;
		wr(OFF_CORE_CFG, 32'h0000_0090);
		run(32'h7FFF_FFFF, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		wr(OFF_COMMAND, cw(OP_ADD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, SAT40_MAX);
		rdc(OFF_STATUS, 32'h0000_0024);
		run(32'h8000_0000, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		wr(OFF_COMMAND, cw(OP_ADD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, SAT40_MIN);
		run(32'h7FFF_FFFF, cw(OP_LOAD, 1'b1, 5'h18, 1'b0, 1'b0, 1'b0));
		wr(OFF_COMMAND, cw(OP_ADD, 1'b1, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b1, 40'hFF_FFFF_FE00);
		run(32'h0000_0000, cw(OP_LOAD, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0));
		rdc(OFF_STATUS, 32'h0000_002C);
		wr(OFF_STATUS, 32'h0000_000C);
		rdc(OFF_STATUS, 32'h0000_0000);
		$display("test sat40 done");
	endtask
	// 32-bit clipping; guard flags must stay clear
	task automatic t_sat32;
		wr(OFF_CORE_CFG, 32'h0000_0080);
		run(32'h7FFF_FFFF, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, SAT32_MAX);
		rdc(OFF_STATUS, 32'h0000_0024);
		run(32'h8000_0000, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, SAT32_MIN);
		wr(OFF_STATUS, 32'h0000_0004);
		run(32'h0000_0001, cw(OP_SUB, 1'b0, 5'h00, 1'b1, 1'b0, 1'b0));
		acc(1'b0, 40'h00_7FFF_FFFF);
		$display("test sat32 done");
	endtask
	// no clipping: accumulator wraps, catastrophic trap fires once
	task automatic t_cat;
		wr(OFF_STATUS, 32'h0000_004C);
		wr(OFF_CORE_CFG, 32'h0000_0010);
		wr(OFF_TRAP_CTL, 32'h0000_0004);
		t0 = traps;
		run(32'h7FFF_FFFF, cw(OP_LOAD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		wr(OFF_COMMAND, cw(OP_ADD, 1'b0, 5'h18, 1'b0, 1'b0, 1'b0));
		acc(1'b0, 40'hFF_FFFF_FE00);
		rdc(OFF_STATUS, 32'h0000_0064);
		chk({24'h0, traps - t0}, 32'h0000_0001);
		wr(OFF_TRAP_CTL, 32'h0000_0000);
		wr(OFF_STATUS, 32'h0000_004C);
		$display("test catastrophic done");
	endtask
	// load A, store it to 0x0100 and compare the word seen by the partner
	task automatic st(input logic [31:0] v, input logic [4:0] sh, input logic [7:0] cfg,
			input logic [3:0] op, input logic [15:0] e);
		wr(OFF_CORE_CFG, {24'h0, cfg});
		run(v, cw(OP_LOAD, 1'b0, sh, 1'b0, 1'b0, 1'b0));
		t0 = xm_count;
		run(32'h0000_0100, cw(op, 1'b0, 5'h00, 1'b0, 1'b0, 1'b0));
		rdc(OFF_STORE_WORD, {16'h0, e});
		chk({24'h0, xm_count - t0}, 32'h0000_0001);
		chk({xm_addr, xm_data}, {16'h0100, e});
	endtask
	task automatic t_round;
		st(32'h1234_8000, 5'h00, 8'h00, OP_STORE_R, 16'h1235);
		st(32'h1234_7FFF, 5'h00, 8'h00, OP_STORE_R, 16'h1234);
		st(32'h1234_8000, 5'h00, 8'h02, OP_STORE_R, 16'h1234);
		st(32'h1235_8000, 5'h00, 8'h02, OP_STORE_R, 16'h1236);
		st(32'h1234_FFFF, 5'h00, 8'h00, OP_STORE_T, 16'h1234);
		st(32'h7FFF_FFFF, 5'h18, 8'h30, OP_STORE_T, 16'h7FFF);
		st(32'h7FFF_FFFF, 5'h18, 8'h10, OP_STORE_T, 16'hFFFF);
		st(32'h8000_0000, 5'h18, 8'h30, OP_STORE_T, 16'h8000);
		$display("test round done");
	endtask
	// write-back of the non-target accumulator, and ops that must not write back
	task automatic t_wb;
		dacsr_op_e ex[4] = '{OP_MPY, OP_NEGATED_MULTIPLY, OP_ED, OP_SQUARED_DIFFERENCE_ACCUMULATE};
		wr(OFF_CORE_CFG, 32'h0000_0000);
		run(32'h5678_8000, cw(OP_LOAD, 1'b1, 5'h00, 1'b0, 1'b0, 1'b0));
		wr(OFF_WB_REG, 32'h0000_0200);
		t0 = xm_count;
		run(32'h0000_0000, cw(OP_MAC, 1'b0, 5'h00, 1'b0, 1'b1, 1'b1));
		rdc(OFF_WB_REG, 32'h0000_0202);
		chk({xm_addr, xm_data}, 32'h0200_5679);
		wr(OFF_COMMAND, cw(OP_MSC, 1'b0, 5'h00, 1'b1, 1'b1, 1'b0));
		rdc(OFF_WB_REG, 32'h0000_5679);
		foreach (ex[i]) wr(OFF_COMMAND, cw(ex[i], 1'b0, 5'h00, 1'b0, 1'b1, 1'b1));
		rdc(OFF_WB_REG, 32'h0000_5679);
		chk({24'h0, xm_count - t0}, 32'h0000_0001);
		$display("test writeback done");
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// main sequence
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_guard;
		t_sat40;
		t_sat32;
		t_cat;
		t_round;
		t_wb;
		give_verdict;
	end
	// watchdog well past the roughly 400 cycles the tests need
	initial begin
		#500000;
		mismatches++;
		give_verdict;
	end
endmodule // tb_dsp_accumulator_saturation_round
`default_nettype wire
